// >>> verilog/abwk_defs.svh
`ifndef ABWK_DEFS_SVH
`define ABWK_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ABWK_OFS_CTRL 8'h00
`define ABWK_OFS_DIV_LO 8'h04
`define ABWK_OFS_DIV_HI 8'h08
`define ABWK_OFS_RXBUF 8'h0C
`define ABWK_OFS_STATUS 8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ABWK_CTRL_AUTOBAUD 0
`define ABWK_CTRL_WAKE 1
`define ABWK_CTRL_WIDE 2
`define ABWK_CTRL_HSPD 3
`define ABWK_CTRL_ASYNC 4

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ABWK_STAT_FLAG 0
`define ABWK_STAT_IDLE 1
`define ABWK_STAT_CAL 2
`define ABWK_STAT_WAKE 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ABWK_CTRL_RST 5'h10
`define ABWK_DIV_RST 16'h0000

// ----------------------------------------
// Autobaud clock dividers and counts
// ----------------------------------------
`define ABWK_DIV_SLOW 10'd512
`define ABWK_DIV_MID 10'd128
`define ABWK_DIV_FAST 10'd32
`define ABWK_CNT_START 16'h0001
`define ABWK_LAST_RISE 3'd5

`endif

// >>> verilog/abwk_pkg.sv
package abwk_pkg;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAKE_WATCH,
		ST_WAKE_LOW,
		ST_CAL_START,
		ST_CAL_BIT0,
		ST_CAL_COUNT
	} abwk_state_t;

endpackage

// >>> verilog/abwk_top.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "abwk_defs.svh"

// Contract
// - Setting autobaud enable starts calibration; receiver is held idle meanwhile.
// - Calibration times a received 0x55 sync character with five rising edges.
// - Counter starts at first rising edge after start bit, on autobaud clock.
// - Fifth rising edge stops counting; value stays in divisor registers.
// - On completion hardware clears autobaud enable and sets receive flag.
// - Reading receive buffer clears receive flag, after calibration or wake.
// - Both divisor registers form one 16-bit counter during calibration.
// - Counter advances at one eighth of normal base clock rate.
// - Autobaud clock is Fosc/512, Fosc/128 or Fosc/32 by select bits.
// - Counter starts at 1; software may subtract one afterwards.
// - With both enables set, autobaud runs on character after the break.
// - In sleep the rate generator stops; no normal reception.
// - Wake on break works only in asynchronous mode.
// - While wake enabled, reception is disabled and line is watched.
// - Falling edge on receive line is wake event; flag set then.
// - Wake interrupt synchronous when awake, asynchronous while sleeping.
// - Rising edge ending break clears wake enable; then wait idle.
module abwk_top (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SERIAL_IN_LINE,
	input wire logic SLEEP_MODE,
	output logic RECEIVE_FLAG,
	output logic WAKE_REQUEST,
	output logic RECEIVE_HOLD_IDLE,
	output logic RECEIVE_IDLE_FLAG
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	abwk_pkg::abwk_state_t state_q;
	abwk_pkg::abwk_state_t state_d;
	logic autobaud_enable_q;
	logic wake_on_break_enable_q;
	logic wide_q;
	logic hspd_q;
	logic async_q;
	logic flag_q;
	logic [7:0] div_lo_q;
	logic [7:0] div_hi_q;
	logic [9:0] presc_q;
	logic [2:0] rises_q;
	logic rx_prev_q;
	logic [31:0] prdata_q;
	logic rx_fall;
	logic rx_rise;
	logic cal_tick;
	logic cal_done;
	logic wake_event;
	logic wake_end;
	logic setup_rd;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic counting;
	logic ctrl_wr;
	logic rxbuf_rd;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Autobaud clock period is eight base periods
	function automatic logic [9:0] cal_period_f(input logic wide, input logic hspd);
		logic [9:0] p;
		p = `ABWK_DIV_MID;
		if (!wide && !hspd) begin
			p = `ABWK_DIV_SLOW;
		end else if (wide && hspd) begin
			p = `ABWK_DIV_FAST;
		end
		return p;
	endfunction

	function automatic logic addr_valid_f(input logic [7:0] a);
		return (a == `ABWK_OFS_CTRL) || (a == `ABWK_OFS_DIV_LO) ||
			(a == `ABWK_OFS_DIV_HI) || (a == `ABWK_OFS_RXBUF) ||
			(a == `ABWK_OFS_STATUS);
	endfunction

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Zero wait states; read data is captured in the setup cycle
	assign addr_ok = addr_valid_f(PADDR);
	assign setup_rd = PSEL && !PENABLE && !PWRITE;
	assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
	assign rd_en = PSEL && PENABLE && !PWRITE && addr_ok;
	assign ctrl_wr = wr_en && (PADDR == `ABWK_OFS_CTRL);
	assign rxbuf_rd = rd_en && (PADDR == `ABWK_OFS_RXBUF);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
	assign PRDATA = prdata_q;

	// ----------------------------------------
	// Line edges
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= SERIAL_IN_LINE;
		end
	end

	assign rx_fall = rx_prev_q && !SERIAL_IN_LINE;
	assign rx_rise = !rx_prev_q && SERIAL_IN_LINE;

	// ----------------------------------------
	// Event terms
	// ----------------------------------------
	assign counting = (state_q == abwk_pkg::ST_CAL_COUNT);
	assign cal_done = counting && !SLEEP_MODE && rx_rise &&
		(rises_q == (`ABWK_LAST_RISE - 3'd1));
	assign wake_event = (state_q == abwk_pkg::ST_WAKE_WATCH) && rx_fall;
	assign wake_end = (state_q == abwk_pkg::ST_WAKE_LOW) && rx_rise;
	// Prescaler stalls in sleep since its clock is gone
	assign cal_tick = counting && !SLEEP_MODE &&
		(presc_q == cal_period_f(wide_q, hspd_q) - 10'd1);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			abwk_pkg::ST_IDLE: begin
				if (wake_on_break_enable_q && async_q) begin
					state_d = abwk_pkg::ST_WAKE_WATCH;
				end else if (autobaud_enable_q && !SLEEP_MODE) begin
					state_d = abwk_pkg::ST_CAL_START;
				end
			end
			abwk_pkg::ST_WAKE_WATCH: begin
				if (!wake_on_break_enable_q || !async_q) begin
					state_d = abwk_pkg::ST_IDLE;
				end else if (rx_fall) begin
					state_d = abwk_pkg::ST_WAKE_LOW;
				end
			end
			abwk_pkg::ST_WAKE_LOW: begin
				// Back to idle, where a pending autobaud takes the next byte
				if (!wake_on_break_enable_q || rx_rise) begin
					state_d = abwk_pkg::ST_IDLE;
				end
			end
			abwk_pkg::ST_CAL_START: begin
				if (!autobaud_enable_q) begin
					state_d = abwk_pkg::ST_IDLE;
				end else if (rx_fall && !SLEEP_MODE) begin
					state_d = abwk_pkg::ST_CAL_BIT0;
				end
			end
			abwk_pkg::ST_CAL_BIT0: begin
				if (!autobaud_enable_q) begin
					state_d = abwk_pkg::ST_IDLE;
				end else if (rx_rise && !SLEEP_MODE) begin
					state_d = abwk_pkg::ST_CAL_COUNT;
				end
			end
			abwk_pkg::ST_CAL_COUNT: begin
				if (!autobaud_enable_q || cal_done) begin
					state_d = abwk_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = abwk_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= abwk_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Prescaler and edge count
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			presc_q <= 10'h000;
		end else if (!counting || cal_tick) begin
			presc_q <= 10'h000;
		end else if (!SLEEP_MODE) begin
			presc_q <= presc_q + 10'd1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rises_q <= 3'd0;
		end else if (state_q == abwk_pkg::ST_CAL_BIT0) begin
			rises_q <= 3'd1;
		end else if (counting && rx_rise && !SLEEP_MODE) begin
			rises_q <= rises_q + 3'd1;
		end
	end

	// ----------------------------------------
	// Control bits
	// ----------------------------------------
	// A software write in the same cycle as a hardware clear wins
	always_ff @(posedge CLK) begin
		if (SRST) begin
			autobaud_enable_q <= 1'((`ABWK_CTRL_RST >> `ABWK_CTRL_AUTOBAUD) & 5'h01);
		end else if (ctrl_wr) begin
			autobaud_enable_q <= PWDATA[`ABWK_CTRL_AUTOBAUD];
		end else if (cal_done) begin
			autobaud_enable_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			wake_on_break_enable_q <= 1'((`ABWK_CTRL_RST >> `ABWK_CTRL_WAKE) & 5'h01);
		end else if (ctrl_wr) begin
			wake_on_break_enable_q <= PWDATA[`ABWK_CTRL_WAKE];
		end else if (wake_end) begin
			wake_on_break_enable_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			wide_q <= 1'((`ABWK_CTRL_RST >> `ABWK_CTRL_WIDE) & 5'h01);
		end else if (ctrl_wr) begin
			wide_q <= PWDATA[`ABWK_CTRL_WIDE];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			hspd_q <= 1'((`ABWK_CTRL_RST >> `ABWK_CTRL_HSPD) & 5'h01);
		end else if (ctrl_wr) begin
			hspd_q <= PWDATA[`ABWK_CTRL_HSPD];
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			async_q <= 1'((`ABWK_CTRL_RST >> `ABWK_CTRL_ASYNC) & 5'h01);
		end else if (ctrl_wr) begin
			async_q <= PWDATA[`ABWK_CTRL_ASYNC];
		end
	end

	// ----------------------------------------
	// Divisor pair
	// ----------------------------------------
	// Software writes are dropped while calibration owns the pair
	always_ff @(posedge CLK) begin
		if (SRST) begin
			div_lo_q <= 8'(`ABWK_DIV_RST & 16'h00FF);
			div_hi_q <= 8'(`ABWK_DIV_RST >> 8);
		end else if (state_q == abwk_pkg::ST_CAL_BIT0 && rx_rise && !SLEEP_MODE) begin
			{div_hi_q, div_lo_q} <= `ABWK_CNT_START;
		end else if (cal_tick && !cal_done) begin
			{div_hi_q, div_lo_q} <= {div_hi_q, div_lo_q} + 16'd1;
		end else if (wr_en && !counting && PADDR == `ABWK_OFS_DIV_LO) begin
			div_lo_q <= PWDATA[7:0];
		end else if (wr_en && !counting && PADDR == `ABWK_OFS_DIV_HI) begin
			div_hi_q <= PWDATA[7:0];
		end
	end

	// ----------------------------------------
	// Receive flag
	// ----------------------------------------
	// Setting wins over the clearing read
	always_ff @(posedge CLK) begin
		if (SRST) begin
			flag_q <= 1'b0;
		end else if (cal_done || wake_event) begin
			flag_q <= 1'b1;
		end else if (rxbuf_rd) begin
			flag_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Buffer reads return zero; only the clearing side effect matters
	always_ff @(posedge CLK) begin
		if (SRST) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_rd) begin
			unique case (PADDR)
				`ABWK_OFS_CTRL: begin
					prdata_q <= {27'h0000000, async_q, hspd_q, wide_q,
						wake_on_break_enable_q, autobaud_enable_q};
				end
				`ABWK_OFS_DIV_LO: begin
					prdata_q <= {24'h000000, div_lo_q};
				end
				`ABWK_OFS_DIV_HI: begin
					prdata_q <= {24'h000000, div_hi_q};
				end
				`ABWK_OFS_STATUS: begin
					prdata_q <= {28'h0000000, wake_on_break_enable_q, counting, RECEIVE_IDLE_FLAG, flag_q};
				end
				default: begin
					prdata_q <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign RECEIVE_FLAG = flag_q;
	// Combinational so it reaches the core while its clocks are stopped
	assign WAKE_REQUEST = flag_q || (SLEEP_MODE && wake_on_break_enable_q && async_q &&
		state_q == abwk_pkg::ST_WAKE_WATCH && !SERIAL_IN_LINE);
	assign RECEIVE_HOLD_IDLE = autobaud_enable_q || wake_on_break_enable_q ||
		SLEEP_MODE;
	assign RECEIVE_IDLE_FLAG = (state_q == abwk_pkg::ST_IDLE) ||
		(state_q == abwk_pkg::ST_WAKE_WATCH) || (state_q == abwk_pkg::ST_CAL_START);

endmodule

// >>> dv/abwk_props.sv
`timescale 1ns/1ps
`include "abwk_defs.svh"
// ----------------------------------------
// Checker
// ----------------------------------------
module abwk_props (
	input wire logic CLK,
	input wire logic SRST,
	input wire logic PSEL,
	input wire logic PWRITE,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic SLEEP_MODE,
	input wire logic RECEIVE_FLAG,
	input wire logic WAKE_REQUEST,
	input wire logic RECEIVE_HOLD_IDLE,
	input wire logic RECEIVE_IDLE_FLAG
);
	logic rd_buf;
	assign rd_buf = PSEL && !PWRITE && (PADDR == `ABWK_OFS_RXBUF);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Sequencer leaves a busy state as the enables drop
	sequence s_cal_end;
		$fell(RECEIVE_HOLD_IDLE) ##0 !$past(RECEIVE_IDLE_FLAG);
	endsequence
	chk_sleep_holds: assert property (SLEEP_MODE |-> RECEIVE_HOLD_IDLE)
		else $error("receiver not held in sleep");
	chk_busy_held: assert property (!RECEIVE_IDLE_FLAG |-> RECEIVE_HOLD_IDLE)
		else $error("sequencer busy without hold");
	chk_enable_idle: assert property ($rose(RECEIVE_HOLD_IDLE) |-> RECEIVE_IDLE_FLAG)
		else $error("sequencer left idle too early");
	chk_flag_stays: assert property (RECEIVE_FLAG && !rd_buf |=> RECEIVE_FLAG)
		else $error("flag lost without read");
	chk_read_clears: assert property (rd_buf && PENABLE && !RECEIVE_HOLD_IDLE |=> !RECEIVE_FLAG)
		else $error("flag not cleared by read");
	chk_flag_cause: assert property ($rose(RECEIVE_FLAG) |-> $past(RECEIVE_HOLD_IDLE))
		else $error("flag set with no sequence");
	chk_cal_flag: assert property (s_cal_end |-> RECEIVE_FLAG)
		else $error("sequence ended without flag");
	chk_awake_sync: assert property (!SLEEP_MODE |-> WAKE_REQUEST == RECEIVE_FLAG)
		else $error("wake request not flag when awake");
	chk_sleep_wake: assert property (SLEEP_MODE && RECEIVE_FLAG |-> WAKE_REQUEST)
		else $error("no wake request in sleep");
endmodule
bind abwk_top abwk_props chk_u (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PWRITE(PWRITE),
	.PENABLE(PENABLE), .PADDR(PADDR), .SLEEP_MODE(SLEEP_MODE), .RECEIVE_FLAG(RECEIVE_FLAG),
	.WAKE_REQUEST(WAKE_REQUEST), .RECEIVE_HOLD_IDLE(RECEIVE_HOLD_IDLE),
	.RECEIVE_IDLE_FLAG(RECEIVE_IDLE_FLAG));

// >>> dv/abwk_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote node
// ----------------------------------------
module abwk_node (
	input wire logic clk,
	output logic line
);
	// Idle high between frames
	initial line = 1'b1;
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge clk);
	endtask
	// Start, 0x55 lsb first, stop
	task automatic send_sync(input int p);
		logic [9:0] f;
		f = {1'b1, 8'h55, 1'b0};
		for (int i = 0; i < 10; i++) begin
			hold(f[i], p);
		end
	endtask
endmodule

// >>> dv/abwk_top_bench.sv
`timescale 1ns/1ps
`include "abwk_defs.svh"
// ----------------------------------------
// Bench
// ----------------------------------------
module abwk_top_bench;
	logic clk, srst, psel, penable, pwrite, sleep, pready, pslverr, e;
	logic flag, wreq, hidle, ridle, line;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fails, cmp_count;
	abwk_top dut_u (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SERIAL_IN_LINE(line), .SLEEP_MODE(sleep), .RECEIVE_FLAG(flag), .WAKE_REQUEST(wreq),
		.RECEIVE_HOLD_IDLE(hidle), .RECEIVE_IDLE_FLAG(ridle));
	abwk_node node_u (.clk(clk), .line(line));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Ports are looked at mid-cycle, away from the edge
	task look(input logic v, input logic x);
		@(negedge clk);
		chk(32'(v), 32'(x));
		@(posedge clk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task t_regs;
		apb(0, `ABWK_OFS_CTRL, 0);
		chk(q, 32'h10);
		look(ridle, 1);
		apb(0, 8'h14, 0);
		chk(32'(e), 32'h1);
	endtask
	// Bit time of 2x+1/16 counter periods: result is phase-proof
	task automatic t_autobaud;
		int dv[4] = '{512, 128, 128, 32};
		int p, x;
		for (int m = 0; m < 4; m++) begin
			x = (m == 3) ? 33 : 1;
			p = dv[m] * 2 * x + dv[m] / 16;
			apb(1, `ABWK_OFS_CTRL, 32'h11 | (m << 2));
			look(hidle, 1);
			node_u.send_sync(p);
			apb(0, `ABWK_OFS_CTRL, 0);
			chk(q, 32'h10 | (m << 2));
			look(flag, 1);
			apb(0, `ABWK_OFS_DIV_LO, 0);
			chk(q, (16 * x + 1) & 32'hFF);
			apb(0, `ABWK_OFS_DIV_HI, 0);
			chk(q, (16 * x + 1) >> 8);
			apb(0, `ABWK_OFS_RXBUF, 0);
			look(flag, 0);
		end
	endtask
	task t_wake;
		apb(1, `ABWK_OFS_CTRL, 32'h12);
		sleep <= 1'b1;
		node_u.hold(0, 20);
		look(flag, 1);
		look(wreq, 1);
		look(hidle, 1);
		look(ridle, 0);
		apb(0, `ABWK_OFS_STATUS, 0);
		chk(q, 32'h9);
		node_u.hold(0, 620);
		sleep <= 1'b0;
		node_u.hold(1, 4);
		apb(0, `ABWK_OFS_CTRL, 0);
		chk(q, 32'h10);
		apb(0, `ABWK_OFS_RXBUF, 0);
		look(flag, 0);
	endtask
	task t_wake_autobaud;
		apb(1, `ABWK_OFS_CTRL, 32'h1F);
		node_u.hold(0, 660);
		node_u.hold(1, 66);
		look(flag, 1);
		apb(0, `ABWK_OFS_RXBUF, 0);
		node_u.send_sync(66);
		apb(0, `ABWK_OFS_CTRL, 0);
		chk(q, 32'h1C);
		apb(0, `ABWK_OFS_DIV_LO, 0);
		chk(q, 32'h11);
		apb(0, `ABWK_OFS_RXBUF, 0);
	endtask
	task t_sync_mode;
		apb(1, `ABWK_OFS_CTRL, 32'h02);
		node_u.hold(0, 40);
		look(flag, 0);
		node_u.hold(1, 4);
		apb(1, `ABWK_OFS_CTRL, 32'h10);
	endtask
	task print_verdict;
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Whole run is about 39k cycles
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		print_verdict;
	end
	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep = 1'b0;
		fails = 0;
		cmp_count = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_autobaud;
		t_wake;
		t_wake_autobaud;
		t_sync_mode;
		print_verdict;
	end
endmodule
